/* File: core/status_led_pkg.sv */
/*
  Constants for the system status indicator encoder: register map,
  field positions, reset values and blink timebase.
  Assumes a 125 MHz ref_clk and a classic Wishbone register bus.
*/
`default_nettype none
package status_led_pkg;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned SLOW_BLINK_HZ = 1;
  localparam int unsigned FAST_BLINK_HZ = 3;
  // Half periods, 50 percent duty
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);

  // Register byte offsets
  localparam logic [7:0] OFF_POWER  = 8'h00;
  localparam logic [7:0] OFF_HEALTH = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // POWER register fields
  localparam int POW_AC_PRESENT = 0;
  localparam int POW_S0         = 1;
  localparam int POW_S4         = 2;
  localparam int POW_S5         = 3;
  localparam int POW_LOW_OFF    = 4;
  localparam int POW_MGMT_UP    = 5;
  localparam int POW_LOADER     = 6;
  localparam int POW_OS_BOOT    = 7;
  localparam int POW_WIDTH      = 8;

  // HEALTH register fields, one per condition
  localparam int H_REDUND_LOSS  = 0;
  localparam int H_FAN_WARN     = 1;
  localparam int H_NONCRIT      = 2;
  localparam int H_PSU_PREDICT  = 3;
  localparam int H_DIMM_DISABLE = 4;
  localparam int H_SPARE_MIGR   = 5;
  localparam int H_MIRROR_UE    = 6;
  localparam int H_MIRROR_CE    = 7;
  localparam int H_BATTERY      = 8;
  localparam int H_MGMT_WDOG    = 9;
  localparam int H_PWR_CFG      = 10;
  localparam int H_DRIVE_CTRL   = 11;
  localparam int H_CRIT         = 12;
  localparam int H_REG_HOT      = 13;
  localparam int H_FAN_SHORT    = 14;
  localparam int H_FATAL        = 15;
  localparam int HEALTH_WIDTH   = 16;
  localparam int GREEN_FIRST    = 0;
  localparam int GREEN_LAST     = 11;
  localparam int AMBER_FIRST    = 12;
  localparam int AMBER_LAST     = 14;

  // CTRL fields
  localparam int CTRL_FAN_REDUNDANT = 0;
  localparam int CTRL_PSU_REDUNDANT = 1;
  localparam int CTRL_WIDTH         = 2;

  localparam logic [POW_WIDTH-1:0]    POWER_RESET  = 8'h00;
  localparam logic [HEALTH_WIDTH-1:0] HEALTH_RESET = 16'h0000;
  localparam logic [CTRL_WIDTH-1:0]   CTRL_RESET   = 2'h3;

  typedef enum logic [4:0] {
    SHOW_OFF        = 5'h01,
    SHOW_GREEN      = 5'h02,
    SHOW_GREEN_BLNK = 5'h04,
    SHOW_AMBER_BLNK = 5'h08,
    SHOW_AMBER      = 5'h10
  } show_type;

endpackage
`default_nettype wire

/* File: core/blink_if.sv */
/*
  Interface carrying the blink phases from the timebase to the encoder.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface blink_if;
  logic slowPhase;
  logic fastPhase;
  modport source (output slowPhase, output fastPhase);
  modport sink   (input slowPhase, input fastPhase);
endinterface
`default_nettype wire

/* File: core/blink_timebase.sv */
/*
  Free-running blink timebase: about 1 Hz and 3 Hz square waves.
  Assumes ref_clk at the rate in the package.
*/
`timescale 1ns/1ps
`default_nettype none
module blink_timebase #(
  parameter int unsigned SLOW_HALF = status_led_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = status_led_pkg::FAST_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  blink_if.source  phases
);

  logic [31:0] slowCnt_q;
  logic [31:0] fastCnt_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slowCnt_q        <= 32'h0;
      phases.slowPhase <= 1'b0;
    end else if (slowCnt_q == SLOW_HALF - 1) begin
      slowCnt_q        <= 32'h0;
      phases.slowPhase <= ~phases.slowPhase;
    end else begin
      slowCnt_q <= slowCnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fastCnt_q        <= 32'h0;
      phases.fastPhase <= 1'b0;
    end else if (fastCnt_q == FAST_HALF - 1) begin
      fastCnt_q        <= 32'h0;
      phases.fastPhase <= ~phases.fastPhase;
    end else begin
      fastCnt_q <= fastCnt_q + 32'h1;
    end
  end

endmodule
`default_nettype wire

/* File: core/system_status_led_encoder.sv */
/*
  System status indicator encoder: two-colour green/amber LED plus the
  chassis identify indicator, driven from power and health flags written over
  classic Wishbone by the management controller.
  Assumes a single ref_clk domain and a Wishbone master keeping stb
  high until ack.
*/
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module system_status_led_encoder #(
  parameter int unsigned SLOW_HALF = status_led_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = status_led_pkg::FAST_HALF_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        greenLed,
  output var  logic        amberLed,
  output var  logic        chassis_identify_indicator
);

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [status_led_pkg::POW_WIDTH-1:0]    power_q;
  logic [status_led_pkg::HEALTH_WIDTH-1:0] health_q;
  logic [status_led_pkg::CTRL_WIDTH-1:0]   ctrl_q;
  status_led_pkg::show_type                show_q;
  status_led_pkg::show_type                show_d;
  logic                                    req;
  logic                                    wrEn;

  // Ack one cycle after stb, then low for a cycle
  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrEn = req & wb_we_i;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power_q <= status_led_pkg::POWER_RESET;
    end else if (wrEn && wb_adr_i == status_led_pkg::OFF_POWER && wb_sel_i[0]) begin
      power_q <= wb_dat_i[status_led_pkg::POW_WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      health_q <= status_led_pkg::HEALTH_RESET;
    end else if (wrEn && wb_adr_i == status_led_pkg::OFF_HEALTH) begin
      if (wb_sel_i[0]) begin
        health_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        health_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= status_led_pkg::CTRL_RESET;
    end else if (wrEn && wb_adr_i == status_led_pkg::OFF_CTRL && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[status_led_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Unmapped offsets read zero and writes are dropped, still acked
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        status_led_pkg::OFF_POWER:  wb_dat_o <= {24'h0, power_q};
        status_led_pkg::OFF_HEALTH: wb_dat_o <= {16'h0, health_q};
        status_led_pkg::OFF_CTRL:   wb_dat_o <= {30'h0, ctrl_q};
        status_led_pkg::OFF_STATUS: wb_dat_o <= {24'h0, chassis_identify_indicator,
                                                 amberLed, greenLed, show_q};
        default:                    wb_dat_o <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Blink timebase

  blink_if phases ();

  blink_timebase #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_timebase (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .phases  (phases)
  );

  ////////////////////////////////////////////////////////////////////////
  // Severity encoding

  logic poweredDown;
  logic mgmtBooting;
  logic greenCause;
  logic amberCause;
  logic healthy;
  logic redundLoss;
  logic fanWarn;
  logic psuPredict;

  // Off states: AC missing, low-power off, soft-off, hibernate
  assign poweredDown = ~power_q[status_led_pkg::POW_AC_PRESENT]
                     | power_q[status_led_pkg::POW_LOW_OFF]
                     | power_q[status_led_pkg::POW_S5]
                     | power_q[status_led_pkg::POW_S4];
  assign mgmtBooting = power_q[status_led_pkg::POW_LOADER]
                     | power_q[status_led_pkg::POW_OS_BOOT];

  // Redundancy-dependent causes only count when the subsystem is redundant
  assign redundLoss = health_q[status_led_pkg::H_REDUND_LOSS]
                    & (ctrl_q[status_led_pkg::CTRL_FAN_REDUNDANT]
                     | ctrl_q[status_led_pkg::CTRL_PSU_REDUNDANT]);
  assign fanWarn    = health_q[status_led_pkg::H_FAN_WARN]
                    & ~health_q[status_led_pkg::H_FAN_SHORT];
  assign psuPredict = health_q[status_led_pkg::H_PSU_PREDICT]
                    & ctrl_q[status_led_pkg::CTRL_PSU_REDUNDANT];

  assign greenCause = redundLoss | fanWarn | psuPredict
                    | health_q[status_led_pkg::H_NONCRIT]
                    | health_q[status_led_pkg::H_DIMM_DISABLE]
                    | health_q[status_led_pkg::H_SPARE_MIGR]
                    | health_q[status_led_pkg::H_MIRROR_UE]
                    | health_q[status_led_pkg::H_MIRROR_CE]
                    | (|health_q[status_led_pkg::H_DRIVE_CTRL:status_led_pkg::H_BATTERY])
                    | mgmtBooting;
  assign amberCause = |health_q[status_led_pkg::AMBER_LAST:status_led_pkg::AMBER_FIRST];
  assign healthy    = power_q[status_led_pkg::POW_S0] & power_q[status_led_pkg::POW_MGMT_UP];

  // Priority walks from most to least severe
  always_comb begin
    if (poweredDown) begin
      show_d = status_led_pkg::SHOW_OFF;
    end else if (health_q[status_led_pkg::H_FATAL]) begin
      show_d = status_led_pkg::SHOW_AMBER;
    end else if (amberCause) begin
      show_d = status_led_pkg::SHOW_AMBER_BLNK;
    end else if (greenCause || !healthy) begin
      show_d = status_led_pkg::SHOW_GREEN_BLNK;
    end else begin
      show_d = status_led_pkg::SHOW_GREEN;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      show_q <= status_led_pkg::SHOW_OFF;
    end else begin
      show_q <= show_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // LED drive, registered so outputs come straight from flops

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      greenLed <= 1'b0;
      amberLed <= 1'b0;
    end else begin
      unique case (show_q)
        status_led_pkg::SHOW_OFF: begin
          greenLed <= 1'b0;
          amberLed <= 1'b0;
        end
        status_led_pkg::SHOW_GREEN: begin
          greenLed <= 1'b1;
          amberLed <= 1'b0;
        end
        status_led_pkg::SHOW_GREEN_BLNK: begin
          greenLed <= phases.slowPhase;
          amberLed <= 1'b0;
        end
        status_led_pkg::SHOW_AMBER_BLNK: begin
          greenLed <= 1'b0;
          amberLed <= phases.slowPhase;
        end
        status_led_pkg::SHOW_AMBER: begin
          greenLed <= 1'b0;
          amberLed <= 1'b1;
        end
        default: begin
          greenLed <= 1'b0;
          amberLed <= 1'b0;
        end
      endcase
    end
  end

  // Bootloader phase wins over OS boot if both flags are set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chassis_identify_indicator <= 1'b0;
    end else if (power_q[status_led_pkg::POW_LOADER]) begin
      chassis_identify_indicator <= phases.fastPhase;
    end else begin
      chassis_identify_indicator <= power_q[status_led_pkg::POW_OS_BOOT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_never_both_colours: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(greenLed && amberLed)) else $error("both colours lit");

  a_off_is_dark: assert property (@(posedge ref_clk) disable iff (!rstn)
    poweredDown |=> ##1 (!greenLed && !amberLed)) else $error("indicator lit while off");

  a_healthy_green: assert property (@(posedge ref_clk) disable iff (!rstn)
    (healthy && !poweredDown && !greenCause && !amberCause && !health_q[status_led_pkg::H_FATAL])
      |=> ##1 (greenLed && !amberLed)) else $error("healthy not solid green");

  a_fatal_amber: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && health_q[status_led_pkg::H_FATAL]) |=> ##1 amberLed) else $error("fatal not solid amber");

  a_amber_over_green: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && amberCause && !health_q[status_led_pkg::H_FATAL])
      |=> (show_q == status_led_pkg::SHOW_AMBER_BLNK)) else $error("amber blink not chosen");

  a_green_degraded: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && health_q[status_led_pkg::H_BATTERY] && !amberCause && !health_q[status_led_pkg::H_FATAL])
      |=> (show_q == status_led_pkg::SHOW_GREEN_BLNK)) else $error("battery fault not green blink");

  a_amber_blink_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
    (show_q == status_led_pkg::SHOW_AMBER_BLNK) |=> (amberLed == $past(phases.slowPhase)))
    else $error("amber blink not on phase");

  a_os_boot_solid: assert property (@(posedge ref_clk) disable iff (!rstn)
    (power_q[status_led_pkg::POW_OS_BOOT] && !power_q[status_led_pkg::POW_LOADER])
      |=> chassis_identify_indicator) else $error("identify not solid in os boot");

  a_loader_blink: assert property (@(posedge ref_clk) disable iff (!rstn)
    power_q[status_led_pkg::POW_LOADER] |=> (chassis_identify_indicator == $past(phases.fastPhase)))
    else $error("identify not fast blink in loader");

  a_ack_one_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_ack_o
      |=> !wb_ack_o) else $error("ack longer than one cycle");

  a_ack_answers: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o)
      |=> wb_ack_o) else $error("request not acked");

  a_ack_unasked: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(wb_cyc_i && wb_stb_i)
      |=> !wb_ack_o) else $error("ack without request");

  a_ctrl_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    (req && !wb_we_i && wb_adr_i == status_led_pkg::OFF_CTRL)
      |=> (wb_dat_o == {30'h0, $past(ctrl_q)})) else $error("ctrl read data wrong");

  a_power_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wrEn && wb_adr_i == status_led_pkg::OFF_POWER && wb_sel_i[0])
      |=> ({24'h0, power_q} == ($past(wb_dat_i) & 32'h0000_00ff))) else $error("power write lost");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (req && !wb_we_i && wb_adr_i > status_led_pkg::OFF_STATUS)
      |=> (wb_dat_o == 32'h0)) else $error("unmapped read not zero");

  a_off_show: assert property (@(posedge ref_clk) disable iff (!rstn)
    poweredDown
      |=> (show_q == status_led_pkg::SHOW_OFF)) else $error("off state not chosen");

  a_fatal_chosen: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && health_q[status_led_pkg::H_FATAL])
      |=> (show_q == status_led_pkg::SHOW_AMBER)) else $error("solid amber not chosen");

  a_hot_fans_amber: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && !health_q[status_led_pkg::H_FATAL]
     && (health_q[status_led_pkg::H_REG_HOT] || health_q[status_led_pkg::H_FAN_SHORT]))
      |=> (show_q == status_led_pkg::SHOW_AMBER_BLNK)) else $error("hot or fan short not amber");

  a_boot_degraded: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && mgmtBooting && !amberCause && !health_q[status_led_pkg::H_FATAL])
      |=> (show_q == status_led_pkg::SHOW_GREEN_BLNK)) else $error("boot not green blink");

  a_redund_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && healthy && health_q == 16'h0001 && ctrl_q == 2'h0)
      |=> (show_q == status_led_pkg::SHOW_GREEN)) else $error("loss counted without redundancy");

  a_psu_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && healthy && health_q == 16'h0008 && !ctrl_q[status_led_pkg::CTRL_PSU_REDUNDANT])
      |=> (show_q == status_led_pkg::SHOW_GREEN)) else $error("predictive counted without redundancy");

  a_fan_warn_green: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!poweredDown && health_q == 16'h0002)
      |=> (show_q == status_led_pkg::SHOW_GREEN_BLNK)) else $error("fan warning not green blink");

  a_green_blink_phase: assert property (@(posedge ref_clk) disable iff (!rstn)
    (show_q == status_led_pkg::SHOW_GREEN_BLNK)
      |=> (greenLed == $past(phases.slowPhase) && !amberLed)) else $error("green blink not on phase");

  a_solid_green_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    (show_q == status_led_pkg::SHOW_GREEN)
      |=> (greenLed && !amberLed)) else $error("solid green not driven");

  a_identify_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!power_q[status_led_pkg::POW_LOADER] && !power_q[status_led_pkg::POW_OS_BOOT])
      |=> !chassis_identify_indicator) else $error("identify lit outside boot");

endmodule
`default_nettype wire

/* File: tb/mgmt_ctrl_model.sv */
/*
  Management controller model: classic Wishbone master that writes the
  health and power levels and reads them back.
  Assumes the encoder acks every request and ack is sampled at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_model (
  input  wire logic        ref_clk,
  output var  logic        wbCyc,
  output var  logic        wbStb,
  output var  logic        wbWe,
  output var  logic [7:0]  wbAdr,
  output var  logic [31:0] wbDat,
  output var  logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  input  wire logic        wbAck
);
  // Byte lanes of the next request; the bench narrows it for lane tests
  logic [3:0] selUse = 4'hf;

  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe  = 1'b0;
    wbAdr = 8'h00;
    wbDat = 32'h0;
    wbSel = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Held until ack is seen or 20 cycles pass, then released with adr and dat inverted
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbDat <= dat;
    wbSel <= selUse;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge ref_clk);
      if (wbAck === 1'b1) begin
        ok = 1'b1;
        rd = wbDatIn;
      end
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    wbAdr <= ~adr;
    wbDat <= ~dat;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench for the status indicator encoder.
  Assumes short blink half periods (8 and 3 cycles) set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] datW;
  logic [3:0]  sel;
  logic [31:0] datR;
  logic        ack;
  logic        green;
  logic        amber;
  logic        ident;
  int          error_cnt  = 0;
  int          num_checks = 0;
  // AC present, S0, controller up
  localparam logic [31:0] UP = 32'h23;

  always #4 ref_clk = ~ref_clk;

  system_status_led_encoder #(.SLOW_HALF(8), .FAST_HALF(3)) system_status_led_encoder_i (
    .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack),
    .greenLed(green), .amberLed(amber), .chassis_identify_indicator(ident));

  mgmt_ctrl_model mgmt_ctrl_model_i (
    .ref_clk(ref_clk), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr), .wbDat(datW),
    .wbSel(sel), .wbDatIn(datR), .wbAck(ack));

  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkCnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value at %0t: on count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    bit ok;
    mgmt_ctrl_model_i.access(w, a, d, r, ok);
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: no bus answer", $time);
      conclude();
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chkReg(r & mask, exp);
  endtask

  // Steady LEDs settle two edges after the write
  task automatic setState(input logic [31:0] p, input logic [31:0] h, input logic [31:0] c,
                          input status_led_pkg::show_type s);
    logic [31:0] r;
    bus(1'b1, status_led_pkg::OFF_POWER, p, r);
    bus(1'b1, status_led_pkg::OFF_HEALTH, h, r);
    bus(1'b1, status_led_pkg::OFF_CTRL, c, r);
    repeat (4) @(posedge ref_clk);
    rdChk(status_led_pkg::OFF_STATUS, {27'h0, s}, 32'h1f);
  endtask

  // 48 cycles hold whole periods of both blink rates
  task automatic countOn(output int g, output int a, output int c);
    g = 0;
    a = 0;
    c = 0;
    repeat (48) begin
      @(posedge ref_clk);
      g += int'(green === 1'b1);
      a += int'(amber === 1'b1);
      c += int'(ident === 1'b1);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    logic [31:0] r;
    rdChk(status_led_pkg::OFF_POWER, 32'h0, 32'hffffffff);
    rdChk(status_led_pkg::OFF_HEALTH, 32'h0, 32'hffffffff);
    rdChk(status_led_pkg::OFF_CTRL, 32'h3, 32'hffffffff);
    rdChk(status_led_pkg::OFF_STATUS, 32'h01, 32'hff);
    bus(1'b1, 8'h10, 32'hffffffff, r);
    rdChk(8'h10, 32'h0, 32'hffffffff);
    bus(1'b1, status_led_pkg::OFF_HEALTH, 32'hffffffff, r);
    rdChk(status_led_pkg::OFF_HEALTH, 32'h0000ffff, 32'hffffffff);
    mgmt_ctrl_model_i.selUse = 4'h1;
    bus(1'b1, status_led_pkg::OFF_HEALTH, 32'h0, r);
    mgmt_ctrl_model_i.selUse = 4'hf;
    rdChk(status_led_pkg::OFF_HEALTH, 32'h0000ff00, 32'hffffffff);
  endtask

  task automatic s_off();
    int g;
    int a;
    int c;
    for (int i = 2; i <= 4; i++) begin
      setState(UP | (32'h1 << i), 32'h0, 32'h3, status_led_pkg::SHOW_OFF);
    end
    setState(UP & ~32'h1, 32'h0, 32'h3, status_led_pkg::SHOW_OFF);
    setState(UP | 32'h8, 32'hffff, 32'h3, status_led_pkg::SHOW_OFF);
    countOn(g, a, c);
    chkCnt(g + a, 0);
  endtask

  task automatic s_green();
    int g;
    int a;
    int c;
    setState(UP, 32'h0, 32'h3, status_led_pkg::SHOW_GREEN);
    countOn(g, a, c);
    chkCnt(g, 48);
    chkCnt(a + c, 0);
  endtask

  task automatic s_degraded();
    int g;
    int a;
    int c;
    for (int i = 0; i <= 11; i++) begin
      setState(UP, 32'h1 << i, 32'h3, status_led_pkg::SHOW_GREEN_BLNK);
    end
    countOn(g, a, c);
    chkCnt(g, 24);
    chkCnt(a, 0);
    setState(UP, 32'h1, 32'h0, status_led_pkg::SHOW_GREEN);
    setState(UP, 32'h8, 32'h1, status_led_pkg::SHOW_GREEN);
    setState(UP, 32'h4002, 32'h3, status_led_pkg::SHOW_AMBER_BLNK);
  endtask

  task automatic s_amber();
    int g;
    int a;
    int c;
    for (int i = 12; i <= 14; i++) begin
      setState(UP, (32'h1 << i) | 32'hfff, 32'h3, status_led_pkg::SHOW_AMBER_BLNK);
    end
    countOn(g, a, c);
    chkCnt(a, 24);
    chkCnt(g, 0);
    setState(UP, 32'hffff, 32'h3, status_led_pkg::SHOW_AMBER);
    countOn(g, a, c);
    chkCnt(a, 48);
    chkCnt(g, 0);
  endtask

  task automatic s_boot();
    int g;
    int a;
    int c;
    setState(32'h43, 32'h0, 32'h3, status_led_pkg::SHOW_GREEN_BLNK);
    countOn(g, a, c);
    chkCnt(c, 24);
    chkCnt(g, 24);
    setState(32'h83, 32'h0, 32'h3, status_led_pkg::SHOW_GREEN_BLNK);
    countOn(g, a, c);
    chkCnt(c, 48);
    setState(32'hc3, 32'h0, 32'h3, status_led_pkg::SHOW_GREEN_BLNK);
    countOn(g, a, c);
    chkCnt(c, 24);
    setState(UP, 32'h0, 32'h3, status_led_pkg::SHOW_GREEN);
    countOn(g, a, c);
    chkCnt(c, 0);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    s_reset();
    s_off();
    s_green();
    s_degraded();
    s_amber();
    s_boot();
    conclude();
  end
endmodule
`default_nettype wire
